/* File: xde_pkg.sv */
// package for the byte exclusive-or and low-nibble exchange execution unit
// assumes an 8-bit core with 8-bit internal addresses and single-clock ram/sfr reads
package xde_pkg;

	// ----------------------------------------------------------------
	// opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_XOR_A_RN_BASE  = 8'h68;
	localparam logic [7:0] OP_XOR_A_DIR      = 8'h65;
	localparam logic [7:0] OP_XOR_A_IND_BASE = 8'h66;
	localparam logic [7:0] OP_XOR_A_IMM      = 8'h64;
	localparam logic [7:0] OP_XOR_DIR_A      = 8'h62;
	localparam logic [7:0] OP_XOR_DIR_IMM    = 8'h63;
	localparam logic [7:0] OP_EXCHANGE_LOW_NIBBLE_INSTRUCTION_IND_BASE  = 8'hd6;

	// ----------------------------------------------------------------
	// opcode fields
	// ----------------------------------------------------------------
	localparam int RN_SEL_W  = 3;
	localparam int RI_SEL_W  = 1;
	localparam int BANK_W    = 2;

	// ----------------------------------------------------------------
	// lengths and timing
	// ----------------------------------------------------------------
	localparam logic [1:0] LEN_ONE_BYTE    = 2'h1;
	localparam logic [1:0] LEN_TWO_BYTES   = 2'h2;
	localparam logic [1:0] LEN_THREE_BYTES = 2'h3;
	localparam logic [1:0] MCYC_ONE        = 2'h1;
	localparam logic [1:0] MCYC_TWO        = 2'h2;
	// clocks per machine cycle; must cover the longest internal sequence (4 clocks)
	localparam logic [3:0] MCYC_CLKS       = 4'h6;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		F_A_RN,
		F_A_DIR,
		F_A_IND,
		F_A_IMM,
		F_DIR_A,
		F_DIR_IMM,
		F_EXCHANGE_LOW_NIBBLE_INSTRUCTION
	} xde_form_t;

	typedef enum logic [2:0] {
		S_IDLE,
		S_RD1,
		S_RD2,
		S_WB,
		S_HOLD
	} xde_state_t;

	// bank register address: bank select above the register index
	function automatic logic [7:0] xde_reg_addr(input logic [BANK_W-1:0] bank, input logic [RN_SEL_W-1:0] idx);
		xde_reg_addr = {3'h0, bank, idx};
	endfunction

endpackage

/* File: xde_exec.sv */
// execution unit for the byte exclusive-or family and the low-nibble exchange
// assumes the core holds i_start for one clock with the opcode and following bytes,
// and that ram/sfr read data appears one clock after o_mem_re
//
// Functional notes
// - nibble exchange swaps low nibbles, flags untouched
// - exclusive-or result to destination, flags untouched
// - accumulator destination: register, direct, indirect, immediate
// - direct destination: accumulator or immediate only
// - port destination reads output latch, not pins
// - direct form inverts mask-selected bits anywhere
// - direct,immediate: three bytes, two machine cycles
// - direct,accumulator: two bytes, one machine cycle
// - accumulator,direct: two bytes, one cycle, accumulator only
module xde_exec
	import xde_pkg::*;
(
	input  wire logic                       i_ref_clk,
	input  wire logic                       i_rst,
	input  wire logic                       i_start,
	input  wire logic [7:0]                 i_opcode,
	input  wire logic [7:0]                 i_byte2,
	input  wire logic [7:0]                 i_byte3,
	input  wire logic [xde_pkg::BANK_W-1:0] i_bank,
	input  wire logic [7:0]                 i_acc,
	input  wire logic [7:0]                 i_mem_rdata,
	output logic                            o_busy,
	output logic                            o_done,
	output logic                            o_illegal,
	output logic [1:0]                      o_instr_len,
	output logic                            o_acc_we,
	output logic [7:0]                      o_acc_wdata,
	output logic                            o_mem_re,
	output logic                            o_mem_latch,
	output logic                            o_mem_we,
	output logic [7:0]                      o_mem_addr,
	output logic [7:0]                      o_mem_wdata
);
	import xde_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	xde_state_t state_r;
	xde_form_t  form_r;
	logic [7:0] acc_r;
	logic [7:0] imm_r;
	logic [7:0] opnd_r;
	logic [7:0] dst_addr_r;
	logic [3:0] cnt_r;
	logic [3:0] budget_r;
	logic       done_r;
	logic       illegal_r;
	logic [1:0] len_r;
	logic       acc_we_r;
	logic [7:0] acc_wdata_r;
	logic       mem_re_r;
	logic       mem_latch_r;
	logic       mem_we_r;
	logic [7:0] mem_addr_r;
	logic [7:0] mem_wdata_r;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic      dec_ok;
	xde_form_t dec_form;
	logic [1:0] dec_len;
	logic [1:0] dec_mcyc;

	always_comb begin
		dec_ok   = 1'b1;
		dec_form = F_A_RN;
		dec_len  = LEN_ONE_BYTE;
		dec_mcyc = MCYC_ONE;
		if (i_opcode[7:3] == OP_XOR_A_RN_BASE[7:3]) begin
			dec_form = F_A_RN;
		end else if (i_opcode == OP_XOR_A_DIR) begin
			dec_form = F_A_DIR;
			dec_len  = LEN_TWO_BYTES;
		end else if (i_opcode[7:1] == OP_XOR_A_IND_BASE[7:1]) begin
			dec_form = F_A_IND;
		end else if (i_opcode == OP_XOR_A_IMM) begin
			dec_form = F_A_IMM;
			dec_len  = LEN_TWO_BYTES;
		end else if (i_opcode == OP_XOR_DIR_A) begin
			dec_form = F_DIR_A;
			dec_len  = LEN_TWO_BYTES;
		end else if (i_opcode == OP_XOR_DIR_IMM) begin
			dec_form = F_DIR_IMM;
			dec_len  = LEN_THREE_BYTES;
			dec_mcyc = MCYC_TWO;
		end else if (i_opcode[7:1] == OP_EXCHANGE_LOW_NIBBLE_INSTRUCTION_IND_BASE[7:1]) begin
			dec_form = F_EXCHANGE_LOW_NIBBLE_INSTRUCTION;
		end else begin
			dec_ok = 1'b0;
		end
	end

	// pointer register address for indirect forms, bank register for register form
	logic [7:0] ptr_addr;
	logic [7:0] rn_addr;

	assign ptr_addr = xde_reg_addr(i_bank, {2'h0, i_opcode[RI_SEL_W-1:0]});
	assign rn_addr  = xde_reg_addr(i_bank, i_opcode[RN_SEL_W-1:0]);

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	logic start_ok;
	assign start_ok = i_start && (state_r == S_IDLE) && dec_ok;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state_r <= S_IDLE;
		end else begin
			unique case (state_r)
				S_IDLE: begin
					if (start_ok) begin
						state_r <= (dec_form == F_A_IMM) ? S_WB : S_RD1;
					end
				end
				S_RD1: begin
					state_r <= (form_r == F_A_IND || form_r == F_EXCHANGE_LOW_NIBBLE_INSTRUCTION) ? S_RD2 : S_WB;
				end
				S_RD2: begin
					state_r <= S_WB;
				end
				S_WB: begin
					state_r <= S_HOLD;
				end
				S_HOLD: begin
					if (cnt_r == budget_r - 4'h1) begin
						state_r <= S_IDLE;
					end
				end
			endcase
		end
	end

	// machine-cycle budget: done lands exactly at the documented cycle count
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			cnt_r    <= 4'h0;
			budget_r <= MCYC_CLKS;
			len_r    <= LEN_ONE_BYTE;
		end else if (start_ok) begin
			cnt_r    <= 4'h0;
			budget_r <= (dec_mcyc == MCYC_TWO) ? 4'(MCYC_CLKS * 2) : MCYC_CLKS;
			len_r    <= dec_len;
		end else if (state_r != S_IDLE) begin
			cnt_r <= cnt_r + 4'h1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			done_r    <= 1'b0;
			illegal_r <= 1'b0;
		end else begin
			done_r    <= (state_r == S_HOLD) && (cnt_r == budget_r - 4'h1);
			illegal_r <= i_start && (state_r == S_IDLE) && !dec_ok;
		end
	end

	// ----------------------------------------------------------------
	// operand capture
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			form_r     <= F_A_RN;
			acc_r      <= 8'h00;
			imm_r      <= 8'h00;
			opnd_r     <= 8'h00;
			dst_addr_r <= 8'h00;
		end else if (start_ok) begin
			form_r     <= dec_form;
			acc_r      <= i_acc;
			// immediate sits after the address byte in the three-byte form
			imm_r      <= (dec_form == F_DIR_IMM) ? i_byte3 : i_byte2;
			opnd_r     <= i_byte2;
			dst_addr_r <= i_byte2;
		end else if (state_r == S_RD1 && (form_r == F_A_IND || form_r == F_EXCHANGE_LOW_NIBBLE_INSTRUCTION)) begin
			dst_addr_r <= i_mem_rdata;
		end else if (state_r == S_RD1 || state_r == S_RD2) begin
			opnd_r <= i_mem_rdata;
		end
	end

	// ----------------------------------------------------------------
	// memory reads
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			mem_re_r    <= 1'b0;
			mem_latch_r <= 1'b0;
			mem_addr_r  <= 8'h00;
		end else begin
			mem_re_r    <= 1'b0;
			mem_latch_r <= 1'b0;
			if (start_ok && dec_form != F_A_IMM) begin
				mem_re_r <= 1'b1;
				unique case (dec_form)
					F_A_RN:               mem_addr_r <= rn_addr;
					F_A_IND, F_EXCHANGE_LOW_NIBBLE_INSTRUCTION:      mem_addr_r <= ptr_addr;
					default:              mem_addr_r <= i_byte2;
				endcase
				// read-modify-write of a port must see the output latch, not the pins
				mem_latch_r <= (dec_form == F_DIR_A) || (dec_form == F_DIR_IMM);
			end else if (state_r == S_RD1 && (form_r == F_A_IND || form_r == F_EXCHANGE_LOW_NIBBLE_INSTRUCTION)) begin
				mem_re_r   <= 1'b1;
				mem_addr_r <= i_mem_rdata;
			end else if (state_r == S_WB && (form_r == F_DIR_A || form_r == F_DIR_IMM || form_r == F_EXCHANGE_LOW_NIBBLE_INSTRUCTION)) begin
				mem_addr_r <= dst_addr_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// write back; no flag is ever written by these forms
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			acc_we_r    <= 1'b0;
			acc_wdata_r <= 8'h00;
			mem_we_r    <= 1'b0;
			mem_wdata_r <= 8'h00;
		end else begin
			acc_we_r <= 1'b0;
			mem_we_r <= 1'b0;
			if (state_r == S_WB) begin
				unique case (form_r)
					F_A_RN, F_A_DIR, F_A_IND: begin
						acc_we_r    <= 1'b1;
						acc_wdata_r <= acc_r ^ opnd_r;
					end
					F_A_IMM: begin
						acc_we_r    <= 1'b1;
						acc_wdata_r <= acc_r ^ imm_r;
					end
					F_DIR_A: begin
						mem_we_r    <= 1'b1;
						mem_wdata_r <= opnd_r ^ acc_r;
					end
					F_DIR_IMM: begin
						mem_we_r    <= 1'b1;
						mem_wdata_r <= opnd_r ^ imm_r;
					end
					F_EXCHANGE_LOW_NIBBLE_INSTRUCTION: begin
						acc_we_r    <= 1'b1;
						acc_wdata_r <= {acc_r[7:4], opnd_r[3:0]};
						mem_we_r    <= 1'b1;
						mem_wdata_r <= {opnd_r[7:4], acc_r[3:0]};
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_busy      = (state_r != S_IDLE);
	assign o_done      = done_r;
	assign o_illegal   = illegal_r;
	assign o_instr_len = len_r;
	assign o_acc_we    = acc_we_r;
	assign o_acc_wdata = acc_wdata_r;
	assign o_mem_re    = mem_re_r;
	assign o_mem_latch = mem_latch_r;
	assign o_mem_we    = mem_we_r;
	assign o_mem_addr  = mem_addr_r;
	assign o_mem_wdata = mem_wdata_r;

endmodule

/* File: xde_exec_properties.sv */
// checker: timing and data of the xor / nibble-exchange unit at its ports
// assumes xde_pkg is compiled first; bound into every xde_exec below
module xde_exec_props (
	input wire logic       i_ref_clk,
	input wire logic       i_rst,
	input wire logic       i_start,
	input wire logic [7:0] i_opcode,
	input wire logic [7:0] i_byte2,
	input wire logic [1:0] i_bank,
	input wire logic [7:0] i_acc,
	input wire logic       o_busy,
	input wire logic       o_done,
	input wire logic       o_illegal,
	input wire logic [1:0] o_instr_len,
	input wire logic       o_acc_we,
	input wire logic [7:0] o_acc_wdata,
	input wire logic       o_mem_re,
	input wire logic       o_mem_latch,
	input wire logic       o_mem_we,
	input wire logic [7:0] o_mem_addr
);
	// ----
	// accepted request and opcode classes
	// ----
	wire go = i_start && !o_busy;
	wire legal = i_opcode[7:3] == 5'h0d || i_opcode[7:2] == 6'h19 || i_opcode[7:1] == 7'h31
		|| i_opcode[7:1] == 7'h6b;

	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	// done is registered: it rises at the last edge of the machine cycle and is sampled one edge later
	done_one_mc_a: assert property (go && legal && i_opcode != 8'h63 |-> ##7 o_done)
		else $error("done not six clocks after start");
	done_two_mc_a: assert property (go && i_opcode == 8'h63 |-> ##13 o_done)
		else $error("direct immediate form not done after two machine cycles");
	len_three_a: assert property (go && i_opcode == 8'h63 |=> o_instr_len == 2'h3)
		else $error("direct immediate form length not three");
	busy_hold_a: assert property (go && legal |=> o_busy [*5])
		else $error("busy dropped early");
	illegal_flag_a: assert property (go && !legal |=> o_illegal && !o_busy)
		else $error("foreign opcode not flagged");
	imm_xor_a: assert property (go && i_opcode == 8'h64 |-> ##2 o_acc_we
		&& o_acc_wdata == ($past(i_acc, 2) ^ $past(i_byte2, 2))) else $error("immediate xor wrong");
	port_latch_a: assert property (go && i_opcode[7:1] == 7'h31 |=> o_mem_re && o_mem_latch
		&& o_mem_addr == $past(i_byte2)) else $error("direct destination not read from latch");
	src_pins_a: assert property (go && i_opcode == 8'h65 |=> o_mem_re && !o_mem_latch)
		else $error("direct source read from latch");
	acc_only_a: assert property (go && i_opcode == 8'h65 |=> !o_mem_we [*6])
		else $error("accumulator form wrote memory");
	reg_sel_a: assert property (go && i_opcode[7:3] == 5'h0d |=> o_mem_re
		&& o_mem_addr == ({3'h0, $past(i_bank), 3'h0} | ($past(i_opcode) & 8'h07)))
		else $error("bank register address wrong");

	cover property (go && i_opcode == 8'h63);
	cover property (go && i_opcode[7:1] == 7'h6b);
	cover property (o_illegal);
endmodule

bind xde_exec xde_exec_props i_chk (.i_ref_clk, .i_rst, .i_start, .i_opcode, .i_byte2, .i_bank, .i_acc,
	.o_busy, .o_done, .o_illegal, .o_instr_len, .o_acc_we, .o_acc_wdata, .o_mem_re, .o_mem_latch,
	.o_mem_we, .o_mem_addr);

/* File: xde_exec_tb.sv */
// testbench: table then random mix of the family, ram model, queued write notes
// assumes xde_pkg, xde_exec and the checker are compiled first
module xde_exec_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import xde_pkg::*;

	logic        i_ref_clk   = 1'b0;
	logic        i_rst       = 1'b1;
	logic        i_start     = 1'b0;
	logic [7:0]  i_opcode    = 8'h00;
	logic [7:0]  i_byte2     = 8'h00;
	logic [7:0]  i_byte3     = 8'h00;
	logic [1:0]  i_bank      = 2'h0;
	logic [7:0]  i_acc       = 8'h00;
	logic [7:0]  i_mem_rdata = 8'h00;
	logic        o_busy, o_done, o_illegal, o_acc_we, o_mem_re, o_mem_latch, o_mem_we;
	logic [1:0]  o_instr_len;
	logic [7:0]  o_acc_wdata, o_mem_addr, o_mem_wdata;
	logic [7:0]  mem [256];
	logic [15:0] accq [$];
	logic [15:0] memq [$];
	logic [31:0] rnd         = 32'h8d6dc631;
	int          fails       = 0;
	int          compares    = 0;
	logic        hung        = 1'b0;
	logic [7:0]  ops [16]    = '{8'h68, 8'h6f, 8'h6a, 8'h65, 8'h66, 8'h67, 8'h64, 8'h62,
		8'h63, 8'hd6, 8'hd7, 8'h61, 8'h6d, 8'h69, 8'h63, 8'hd6};

	always #5 i_ref_clk = ~i_ref_clk;

	xde_exec i_dut (.i_ref_clk, .i_rst, .i_start, .i_opcode, .i_byte2, .i_byte3, .i_bank, .i_acc,
		.i_mem_rdata, .o_busy, .o_done, .o_illegal, .o_instr_len, .o_acc_we, .o_acc_wdata, .o_mem_re,
		.o_mem_latch, .o_mem_we, .o_mem_addr, .o_mem_wdata);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic summarize();
		chk("notes left", 16'h0, 16'(accq.size() + memq.size()));
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----
	// ram answers each read at the falling edge of the same cycle and holds it; writes are judged against notes
	// ----
	always @(negedge i_ref_clk) begin
		if (o_mem_re === 1'b1)
			i_mem_rdata <= mem[o_mem_addr];
		if (o_acc_we === 1'b1)
			chk("acc write", accq.size() > 0 ? accq.pop_front() : 'x, {8'h0, o_acc_wdata});
		if (o_mem_we === 1'b1)
			chk("mem write", memq.size() > 0 ? memq.pop_front() : 'x, {o_mem_addr, o_mem_wdata});
	end

	// ----
	// one instruction, issued at a falling edge; returns in its done cycle
	// ----
	task automatic run(input logic [7:0] op);
		logic [7:0] a, b2, b3, m, ra, wd;
		logic [1:0] bk, len;
		int         n;
		rnd = lfsr(rnd);
		a = rnd[7:0];
		b2 = rnd[15:8];
		b3 = rnd[23:16];
		bk = rnd[25:24];
		ra = op[7:3] == 5'h0d ? {3'h0, bk, op[2:0]} : b2;
		if (op[7:1] inside {7'h33, 7'h6b})
			ra = mem[{3'h0, bk, 2'h0, op[0]}];
		m = mem[ra];
		len = op inside {8'h62, 8'h64, 8'h65} ? 2'h2 : op == 8'h63 ? 2'h3 : 2'h1;
		wd = m ^ (op[0] ? b3 : a);
		if (op[7:1] == 7'h6b) begin
			wd = {m[7:4], a[3:0]};
			accq.push_back({8'h0, a[7:4], m[3:0]});
			memq.push_back({ra, wd});
		end else if (op[7:1] == 7'h31)
			memq.push_back({b2, wd});
		else if (op != 8'h61)
			accq.push_back({8'h0, a ^ (op == 8'h64 ? b2 : m)});
		i_start <= 1'b1;
		i_opcode <= op;
		i_byte2 <= b2;
		i_byte3 <= b3;
		i_bank <= bk;
		i_acc <= a;
		@(negedge i_ref_clk);
		i_start <= 1'b0;
		if (op == 8'h61) begin
			chk("illegal", 16'h1, {15'h0, o_illegal});
			// let an edge pass so the next start is not driven in the step that lowered it
			@(negedge i_ref_clk);
			return;
		end
		chk("length", {14'h0, len}, {14'h0, o_instr_len});
		n = 1;
		// a start while busy must be ignored
		while (o_done !== 1'b1 && n < 20) begin
			if (n == 2)
				i_start <= rnd[26];
			if (n == 3)
				i_start <= 1'b0;
			@(negedge i_ref_clk);
			n++;
		end
		// done rises at the edge closing the last machine cycle; n started at the falling edge after start
		chk("done cycle", op == 8'h63 ? 16'(MCYC_CLKS * 2) : 16'(MCYC_CLKS), 16'(n - 1));
		if (n >= 20)
			hung = 1'b1;
		if (op[7:1] inside {7'h31, 7'h6b})
			mem[op[7:1] == 7'h31 ? b2 : ra] = wd;
	endtask

	initial begin
		foreach (mem[k]) begin
			rnd = lfsr(rnd);
			mem[k] = rnd[7:0];
		end
		repeat (20) @(negedge i_ref_clk);
		i_rst <= 1'b0;
		for (int j = 0; j < 200 && !hung; j++)
			run(j < 16 ? ops[j] : ops[rnd[3:0]]);
		summarize();
	end
endmodule
